//--- design/ptp_event_irq_status.sv
// Purpose: Status, arm and interrupt gathering for event output units
// Assumes: Event inputs are one-cycle pulses from core_clk logic
// Notes: APB answers with no wait state
`timescale 1ns/1ps
`default_nettype none
module ptp_event_irq_status
    import ptp_event_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_TOU-1:0] target_late,
    input wire logic [NUM_TOU-1:0] out_fired,
    input wire logic [NUM_CAP-1:0] capture_evt,
    output logic [NUM_TOU-1:0] pulse_out_arm,
    output logic event_irq_summary,
    output logic irq
);
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_SETUP,
        BUS_ACCESS
    } bus_state_t;

    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;

    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic summary_reg;
    logic summary_next;
    logic irq_reg;
    logic irq_next;

    logic hit_out_stat;
    logic hit_irq_stat;
    logic hit_ctrl;
    logic hit_mask;
    logic hit_any;
    logic setup_cycle;
    logic access_cycle;
    logic wr_out_stat;
    logic wr_irq_stat;
    logic wr_ctrl;
    logic wr_mask;
    logic rd_take;
    logic strobe_ok;

    logic [NUM_TOU-1:0] alert_en;
    logic [NUM_TOU-1:0] arm;
    logic [NUM_CAP-1:0] cap_en;
    logic [NUM_TOU+NUM_CAP-1:0] irq_mask;
    logic [NUM_TOU-1:0] tou_irq_now;
    logic [NUM_CAP-1:0] cap_irq_now;

    wire logic [NUM_TOU-1:0] late_set;
    wire logic [NUM_TOU-1:0] late_clr;
    wire logic [NUM_TOU-1:0] done_set;
    wire logic [NUM_TOU-1:0] done_clr;
    wire logic [NUM_TOU+NUM_CAP-1:0] irq_set;
    wire logic [NUM_TOU+NUM_CAP-1:0] irq_clr;

    sticky_if #(.W(NUM_TOU)) late_if ();
    sticky_if #(.W(NUM_TOU)) done_if ();
    sticky_if #(.W(NUM_TOU + NUM_CAP)) irq_if ();

    // Address decode on word address
    always_comb
    begin
        hit_out_stat = (paddr[ADDR_W-1:2] == OUT_STATUS_OFFSET[ADDR_W-1:2]);
        hit_irq_stat = (paddr[ADDR_W-1:2] == IRQ_STATUS_OFFSET[ADDR_W-1:2]);
        hit_ctrl = (paddr[ADDR_W-1:2] == UNIT_CTRL_OFFSET[ADDR_W-1:2]);
        hit_mask = (paddr[ADDR_W-1:2] == IRQ_MASK_OFFSET[ADDR_W-1:2]);
        hit_any = hit_out_stat | hit_irq_stat | hit_ctrl | hit_mask;
    end

    // Bus phase tracking
    always_comb
    begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE:
            begin
                if (psel && !penable)
                begin
                    bus_state_next = BUS_SETUP;
                end
            end
            BUS_SETUP:
            begin
                if (psel && penable)
                begin
                    bus_state_next = BUS_ACCESS;
                end
                else if (!psel)
                begin
                    bus_state_next = BUS_IDLE;
                end
            end
            BUS_ACCESS:
            begin
                if (psel && !penable)
                begin
                    bus_state_next = BUS_SETUP;
                end
                else
                begin
                    bus_state_next = BUS_IDLE;
                end
            end
            default:
            begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_state_reg <= BUS_IDLE;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
        end
    end

    // Ready in the first access cycle; error on unmapped address
    always_comb
    begin
        setup_cycle = psel && !penable;
        access_cycle = psel && penable;
        pready = access_cycle;
        pslverr = access_cycle && !hit_any;
        rd_take = setup_cycle && !pwrite;
    end

    // Access right after a setup; a held access cannot write twice
    always_comb
    begin
        strobe_ok = access_cycle && (bus_state_reg == BUS_SETUP);
    end

    // Register write strobes, one per transfer
    always_comb
    begin
        wr_out_stat = strobe_ok && pwrite && hit_out_stat;
        wr_irq_stat = strobe_ok && pwrite && hit_irq_stat;
        wr_ctrl = strobe_ok && pwrite && hit_ctrl;
        wr_mask = strobe_ok && pwrite && hit_mask;
    end

    // Control field views
    always_comb
    begin
        alert_en = ctrl_reg[ALERT_EN_LSB +: NUM_TOU];
        arm = ctrl_reg[ARM_LSB +: NUM_TOU];
        cap_en = ctrl_reg[CAP_EN_LSB +: NUM_CAP];
        irq_mask = {mask_reg[TOU_IRQ_LSB +: NUM_TOU],
                    mask_reg[CAP_IRQ_LSB +: NUM_CAP]};
    end

    // Irq bank split into output and capture units
    always_comb
    begin
        tou_irq_now = irq_if.value[NUM_CAP +: NUM_TOU];
        cap_irq_now = irq_if.value[NUM_CAP-1:0];
    end

    // Per output unit set and clear strobes
    for (genvar i = 0; i < NUM_TOU; i++)
    begin : g_tou
        assign late_set[i] = alert_en[i] && target_late[i];
        // Disarming by a control write also drops a stale late flag
        assign late_clr[i] = (wr_out_stat && pwdata[LATE_LSB + i])
            || (wr_ctrl && !pwdata[ARM_LSB + i]);
        assign done_set[i] = alert_en[i] && out_fired[i];
        assign done_clr[i] = wr_out_stat && pwdata[DONE_LSB + i];
        // Unit irq gated by its own alert enable
        assign irq_set[NUM_CAP + i] = alert_en[i]
            && (target_late[i] || out_fired[i]);
        assign irq_clr[NUM_CAP + i] = wr_irq_stat
            && pwdata[TOU_IRQ_LSB + i];
    end

    // Per capture unit strobes
    for (genvar j = 0; j < NUM_CAP; j++)
    begin : g_cap
        assign irq_set[j] = cap_en[j] && capture_evt[j];
        assign irq_clr[j] = wr_irq_stat && pwdata[CAP_IRQ_LSB + j];
    end

    assign late_if.set = late_set;
    assign late_if.clr = late_clr;
    assign done_if.set = done_set;
    assign done_if.clr = done_clr;
    assign irq_if.set = irq_set;
    assign irq_if.clr = irq_clr;

    sticky_bank #(
        .W(NUM_TOU),
        .RESET_VALUE(STICKY3_RESET)
    ) u_late (
        .core_clk(core_clk),
        .rst(rst),
        .bank(late_if.owner)
    );

    sticky_bank #(
        .W(NUM_TOU),
        .RESET_VALUE(STICKY3_RESET)
    ) u_done (
        .core_clk(core_clk),
        .rst(rst),
        .bank(done_if.owner)
    );

    sticky_bank #(
        .W(NUM_TOU + NUM_CAP),
        .RESET_VALUE(STICKY5_RESET)
    ) u_irq (
        .core_clk(core_clk),
        .rst(rst),
        .bank(irq_if.owner)
    );

    // Control and mask registers
    always_comb
    begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        if (wr_ctrl)
        begin
            ctrl_next = 32'h0000_0000;
            ctrl_next[ALERT_EN_LSB +: NUM_TOU] =
                pwdata[ALERT_EN_LSB +: NUM_TOU];
            ctrl_next[ARM_LSB +: NUM_TOU] = pwdata[ARM_LSB +: NUM_TOU];
            ctrl_next[CAP_EN_LSB +: NUM_CAP] = pwdata[CAP_EN_LSB +: NUM_CAP];
        end
        // Firing disarms the unit, even against a same-cycle write
        ctrl_next[ARM_LSB +: NUM_TOU] =
            ctrl_next[ARM_LSB +: NUM_TOU] & ~out_fired;
        if (wr_mask)
        begin
            mask_next = 32'h0000_0000;
            mask_next[TOU_IRQ_LSB +: NUM_TOU] =
                pwdata[TOU_IRQ_LSB +: NUM_TOU];
            mask_next[CAP_IRQ_LSB +: NUM_CAP] =
                pwdata[CAP_IRQ_LSB +: NUM_CAP];
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
        end
    end

    // Read data captured in the setup cycle; reserved bits zero
    always_comb
    begin
        prdata_next = prdata_reg;
        if (rd_take)
        begin
            prdata_next = 32'h0000_0000;
            if (hit_out_stat)
            begin
                prdata_next[LATE_LSB +: NUM_TOU] = late_if.value;
                prdata_next[DONE_LSB +: NUM_TOU] = done_if.value;
            end
            else if (hit_irq_stat)
            begin
                prdata_next[TOU_IRQ_LSB +: NUM_TOU] = tou_irq_now;
                prdata_next[CAP_IRQ_LSB +: NUM_CAP] = cap_irq_now;
            end
            else if (hit_ctrl)
            begin
                prdata_next = ctrl_reg;
            end
            else if (hit_mask)
            begin
                prdata_next = mask_reg;
            end
        end
    end

    // Summary and masked interrupt, both registered
    always_comb
    begin
        summary_next = |irq_if.value;
        irq_next = |(irq_if.value & irq_mask);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_reg <= RDATA_RESET;
            summary_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            summary_reg <= summary_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pulse_out_arm = arm;
    assign event_irq_summary = summary_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

//--- design/ptp_event_pkg.sv
// Purpose: Shared constants for the event-unit status and interrupt block
// Assumes: APB with 32-bit data, one word per register
// Notes: Offsets are byte addresses
package ptp_event_pkg;
    localparam int APB_ADDR_W = 12;
    localparam int NUM_TOU = 3;
    localparam int NUM_CAP = 2;

    localparam logic [11:0] OUT_STATUS_OFFSET = 12'h524;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h528;
    localparam logic [11:0] UNIT_CTRL_OFFSET = 12'h5C0;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h5C4;

    // Output status layout
    localparam int LATE_LSB = 16;
    localparam int DONE_LSB = 0;
    // Irq status and mask layout
    localparam int TOU_IRQ_LSB = 16;
    localparam int CAP_IRQ_LSB = 0;
    // Unit control layout
    localparam int ALERT_EN_LSB = 0;
    localparam int ARM_LSB = 8;
    localparam int CAP_EN_LSB = 16;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [2:0] STICKY3_RESET = 3'h0;
    localparam logic [4:0] STICKY5_RESET = 5'h00;
endpackage

//--- design/sticky_if.sv
// Purpose: Set, clear and value of one bank of sticky flags
// Assumes: Set and clear are same-clock one-cycle strobes
// Notes: Owner keeps the flags, user drives the strobes
`timescale 1ns/1ps
`default_nettype none
interface sticky_if #(parameter int W = 3);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] value;

    modport owner
    (
        input set,
        input clr,
        output value
    );
    modport user
    (
        output set,
        output clr,
        input value
    );
endinterface
`default_nettype wire

//--- design/sticky_bank.sv
// Purpose: Bank of sticky flags with write-one-to-clear
// Assumes: Strobes come from the core_clk domain
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module sticky_bank #(
    parameter int W = 3,
    parameter logic [W-1:0] RESET_VALUE = '0
)
(
    input wire logic core_clk,
    input wire logic rst,
    sticky_if.owner bank
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    always_comb
    begin
        flag_next = (flag_reg & ~bank.clr) | bank.set;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            flag_reg <= RESET_VALUE;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign bank.value = flag_reg;
endmodule
`default_nettype wire

//--- testbench/ptp_event_irq_status_monitor.sv
// Purpose: Port assertions for the event status block
// Assumes: Zero-wait APB, one-cycle event pulses
// Notes: Shadows the unit control enables
`timescale 1ns/1ps
`default_nettype none
module ptp_event_irq_status_monitor
    import ptp_event_pkg::*;
#(
    parameter int ADDR_W = APB_ADDR_W
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_TOU-1:0] target_late,
    input wire logic [NUM_TOU-1:0] out_fired,
    input wire logic [NUM_CAP-1:0] capture_evt,
    input wire logic [NUM_TOU-1:0] pulse_out_arm,
    input wire logic event_irq_summary,
    input wire logic irq
);
    logic [11:0] wa;
    logic wr;
    logic hit;
    logic live;
    logic ctrl_wr;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    assign wa = {paddr[11:2], 2'b00};
    assign wr = psel && penable && pwrite;
    assign ctrl_wr = wr && (wa == UNIT_CTRL_OFFSET);
    assign hit = wa inside {OUT_STATUS_OFFSET, IRQ_STATUS_OFFSET,
        UNIT_CTRL_OFFSET, IRQ_MASK_OFFSET};
    assign live = (|((target_late | out_fired) & ctrl_reg[2:0]))
        || (|(capture_evt & ctrl_reg[17:16]));
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr)
        begin
            ctrl_next = pwdata;
        end
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= CTRL_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence quiet_then_set;
        !wr ##1 event_irq_summary;
    endsequence
    sequence fire_seen;
        out_fired != 3'h0;
    endsequence
    a_unmapped_err: assert property (pslverr == (psel && penable && !hit))
        else $error("pslverr wrong");
    a_arm_self_clear: assert property (fire_seen |=>
        (pulse_out_arm & $past(out_fired)) == 3'h0) else $error("arm kept");
    a_arm_hold: assert property (!ctrl_wr && !out_fired |=>
        $stable(pulse_out_arm)) else $error("arm moved");
    a_summary_set: assert property (live |-> ##2 event_irq_summary)
        else $error("summary not set");
    a_summary_gate: assert property ($rose(event_irq_summary) |->
        $past(live, 2)) else $error("summary without event");
    a_summary_hold: assert property (quiet_then_set |=> event_irq_summary)
        else $error("summary dropped");
    a_irq_in_summary: assert property (irq |-> event_irq_summary)
        else $error("irq without summary");
    a_reset_clean: assert property ($fell(rst) |-> !event_irq_summary
        && !irq && pulse_out_arm == 3'h0) else $error("dirty reset");
endmodule
bind ptp_event_irq_status ptp_event_irq_status_monitor #(.ADDR_W(ADDR_W))
    u_monitor (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .target_late, .out_fired, .capture_evt,
    .pulse_out_arm, .event_irq_summary, .irq);
`default_nettype wire

//--- testbench/ptp_event_irq_status_tb.sv
// Purpose: Self-checking bench for the event status block
// Assumes: Zero-wait APB slave, pulses one cycle wide
// Notes: Reads queue their expected word for the watcher
`timescale 1ns/1ps
`default_nettype none
module ptp_event_irq_status_tb
    import ptp_event_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] target_late = 3'h0;
    logic [2:0] out_fired = 3'h0;
    logic [1:0] capture_evt = 2'h0;
    logic [2:0] pulse_out_arm;
    logic event_irq_summary;
    logic irq;
    logic [32:0] exp_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    int i;
    logic [2:0] r;
    always #12.5 core_clk = ~core_clk;
    ptp_event_irq_status DUT (.core_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .target_late,
        .out_fired, .capture_evt, .pulse_out_arm, .event_irq_summary, .irq);
    task automatic test_done();
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task automatic chk_read(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("read %h expected %h", got, exp));
    endtask
    task automatic chk_pin(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("pin %h expected %h", got, exp));
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
        input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            fail("no pready");
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic e);
        exp_q.push_back({e, d});
        apb(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic pulse(input logic [2:0] l, input logic [2:0] f,
        input logic [1:0] c);
        @(posedge core_clk);
        target_late <= l;
        out_fired <= f;
        capture_evt <= c;
        @(posedge core_clk);
        target_late <= 3'h0;
        out_fired <= 3'h0;
        capture_evt <= 2'h0;
        repeat (2) @(posedge core_clk);
    endtask
    // Watcher: pairs each completed read with the oldest note
    always @(posedge core_clk)
    begin
        if (psel && penable && !pwrite && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                fail("unexpected read");
            else
                chk_read({pslverr, prdata}, exp_q.pop_front());
        end
    end
    initial
    begin
        void'($urandom(32'hb863));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(12'h600, 32'h0000_0000, 1'b1);
        for (i = 0; i < 3; i++)
        begin
            wr(UNIT_CTRL_OFFSET, 32'h0000_0101 << i);
            @(negedge core_clk);
            chk_pin(pulse_out_arm, 3'h1 << i);
            pulse(3'h0, 3'h1 << i, 2'h0);
            chk_pin(pulse_out_arm, 3'h0);
            chk_pin({2'b00, event_irq_summary}, 3'h1);
            chk_pin({2'b00, irq}, 3'h0);
            rd(OUT_STATUS_OFFSET, 32'h0000_0001 << i, 1'b0);
            rd(IRQ_STATUS_OFFSET, 32'h0001_0000 << i, 1'b0);
            wr(IRQ_MASK_OFFSET, 32'h0001_0000 << i);
            repeat (2) @(posedge core_clk);
            chk_pin({2'b00, irq}, 3'h1);
            wr(OUT_STATUS_OFFSET, 32'h0000_0000);
            rd(OUT_STATUS_OFFSET, 32'h0000_0001 << i, 1'b0);
            wr(OUT_STATUS_OFFSET, 32'h0000_0001 << i);
            rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
            wr(IRQ_STATUS_OFFSET, 32'h0001_0000 << i);
            repeat (2) @(posedge core_clk);
            chk_pin({2'b00, irq}, 3'h0);
        end
        r = 3'($urandom_range(7, 1));
        wr(UNIT_CTRL_OFFSET, 32'h0000_0707);
        pulse(r, 3'h0, 2'h0);
        rd(OUT_STATUS_OFFSET, {13'h0000, r, 16'h0000}, 1'b0);
        wr(UNIT_CTRL_OFFSET, 32'h0000_0007);
        rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        pulse(r, 3'h0, 2'h0);
        wr(OUT_STATUS_OFFSET, {13'h0000, r, 16'h0000});
        rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        wr(IRQ_STATUS_OFFSET, 32'hFFFF_FFFF);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        wr(UNIT_CTRL_OFFSET, 32'h0000_0000);
        pulse(3'h7, 3'h7, 2'h3);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        for (i = 0; i < 2; i++)
        begin
            wr(UNIT_CTRL_OFFSET, 32'h0001_0000 << i);
            pulse(3'h0, 3'h0, 2'h3);
            rd(IRQ_STATUS_OFFSET, 32'h0000_0001 << i, 1'b0);
            wr(IRQ_STATUS_OFFSET, 32'hFFFF_FFFF);
            rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        end
        repeat (2) @(posedge core_clk);
        chk_pin({2'b00, event_irq_summary}, 3'h0);
        wr(UNIT_CTRL_OFFSET, 32'hFFFF_FFFF);
        rd(UNIT_CTRL_OFFSET, 32'h0003_0707, 1'b0);
        wr(IRQ_MASK_OFFSET, 32'hFFFF_FFFF);
        rd(IRQ_MASK_OFFSET, 32'h0007_0003, 1'b0);
        pulse(3'h7, 3'h7, 2'h3);
        chk_pin({2'b00, irq}, 3'h1);
        rd(UNIT_CTRL_OFFSET, 32'h0003_0007, 1'b0);
        rd(OUT_STATUS_OFFSET, 32'h0007_0007, 1'b0);
        rd(IRQ_STATUS_OFFSET, 32'h0007_0003, 1'b0);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(OUT_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        rd(IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
        @(negedge core_clk);
        chk_pin(pulse_out_arm, 3'h0);
        chk_pin({event_irq_summary, irq, 1'b0}, 3'h0);
        if (exp_q.size() != 0)
            fail("read notes left over");
        test_done();
    end
endmodule
`default_nettype wire
